/* File: logic/sacs_sequencer.v */
// The implementer's own choices: the APB interface to the registers and the register offsets.
`timescale 1ns/1ps
`include "sacs_regs.vh"
module sacs_sequencer #(
    parameter RES_BITS = `SACS_RES_BITS
) (
    // clock and reset
    input  wire                clk_sys,
    input  wire                rst,
    // apb slave
    input  wire                psel,
    input  wire                penable,
    input  wire                pwrite,
    input  wire [11:0]         paddr,
    input  wire [31:0]         pwdata,
    output reg  [31:0]         prdata,
    output wire                pready,
    output wire                pslverr,
    // timer trigger pulses, one per timer source
    input  wire [2:0]          trigger_timer,
    // analog front end
    input  wire                cmp_high,
    output wire                comparator_enable,
    output wire                sample_hold,
    output wire [RES_BITS-1:0] dac_code,
    output wire [3:0]          analog_channel,
    output wire [4:0]          conversion_time_select,
    // interrupt request to the interrupt controller
    output wire                conversion_done_irq
);
    localparam ST_IDLE = 2'h0;
    localparam ST_WAIT = 2'h1;
    localparam ST_SAMP = 2'h2;
    localparam ST_CONV = 2'h3;

    reg  [7:0]          converter_mode_control;
    reg  [7:0]          channel_select_register;
    reg  [15:0]         sw_result_full;
    reg  [15:0]         timer_result_full;
    reg                 done_irq_flag_bit;
    reg                 done_irq_mask_bit;
    reg  [1:0]          state;
    reg  [1:0]          next_state;
    reg  [15:0]         step_cnt;
    reg  [RES_BITS-1:0] conv_cnt;
    reg                 trig_prev;
    wire                trig_sync_sel;
    wire [2:0]          trig_sync;
    wire [RES_BITS-1:0] sar_trial;
    wire [RES_BITS-1:0] sar_mask;

    wire wr_en   = psel && penable && pwrite;
    wire rd_en   = psel && penable && !pwrite;
    wire wr_mc   = wr_en && (paddr == `SACS_ADDR_MODE_CTRL);
    wire wr_cs   = wr_en && (paddr == `SACS_ADDR_CHAN_SEL);
    wire wr_flag = wr_en && (paddr == `SACS_ADDR_IRQ_FLAG);
    wire wr_mask = wr_en && (paddr == `SACS_ADDR_IRQ_MASK);
    wire mapped  = (paddr == `SACS_ADDR_MODE_CTRL) || (paddr == `SACS_ADDR_CHAN_SEL) ||
                   (paddr == `SACS_ADDR_SW_FULL) || (paddr == `SACS_ADDR_SW_HIGH) ||
                   (paddr == `SACS_ADDR_SW_LOW) || (paddr == `SACS_ADDR_TMR_FULL) ||
                   (paddr == `SACS_ADDR_TMR_LOW) || (paddr == `SACS_ADDR_IRQ_FLAG) ||
                   (paddr == `SACS_ADDR_IRQ_MASK) || (paddr == `SACS_ADDR_STATUS);

    assign pready  = 1'b1;
    assign pslverr = psel && penable && !mapped;

    wire       run_bit   = converter_mode_control[`SACS_MC_RUN_BIT];
    wire [1:0] trig_src  = channel_select_register[`SACS_CS_TRIG_MSB:`SACS_CS_TRIG_LSB];
    wire       timer_mode = (trig_src != `SACS_TRIG_SOFTWARE);
    wire [4:0] time_sel  = converter_mode_control[`SACS_MC_TIME_MSB:`SACS_MC_TIME_LSB];

    // step length follows a time field written in the same cycle, so a run write that sets it counts right
    wire [4:0]  time_next = wr_mc ? pwdata[`SACS_MC_TIME_MSB:`SACS_MC_TIME_LSB] : time_sel;
    wire [15:0] step_len  = `SACS_CONV_BASE + (`SACS_CONV_STEP * {11'h000, time_next});

    // synchronise each timer output, select the chosen one
    genvar gi;
    generate
        for (gi = 0; gi < 3; gi = gi + 1) begin : g_trig
            sacs_sync u_sync (
                .clk_sys (clk_sys),
                .rst     (rst),
                .din     (trigger_timer[gi]),
                .dout    (trig_sync[gi])
            );
        end
    endgenerate

    assign trig_sync_sel = (trig_src == 2'h1) ? trig_sync[0] :
                           (trig_src == 2'h2) ? trig_sync[1] :
                           (trig_src == 2'h3) ? trig_sync[2] : 1'b0;
    wire trig_pulse = trig_sync_sel && !trig_prev;

    // run and stop writes, end of a step, last bit step of a conversion
    wire run_set   = wr_mc && pwdata[`SACS_MC_RUN_BIT];
    wire stop_now  = wr_mc && !pwdata[`SACS_MC_RUN_BIT];
    wire step_tick = (step_cnt == 16'h0001);
    wire conv_last = (state == ST_CONV) && step_tick && (conv_cnt == {RES_BITS{1'b0}});
    // a mode control or channel select write in the finishing cycle suppresses store and request
    wire cfg_write = wr_mc || wr_cs;
    wire conv_done = conv_last && !cfg_write;
    wire go_samp   = (next_state == ST_SAMP) && (state != ST_SAMP || wr_cs);

    sacs_sar #(
        .BITS (RES_BITS)
    ) u_sar (
        .clk_sys  (clk_sys),
        .rst      (rst),
        .start    ((state == ST_SAMP) && step_tick && !cfg_write),
        .step     ((state == ST_CONV) && step_tick),
        .cmp_high (cmp_high),
        .trial    (sar_trial),
        .mask     (sar_mask)
    );

    // sequencer next state
    always @* begin
        next_state = state;
        case (state)
            ST_IDLE: begin
                if (run_set) begin
                    next_state = timer_mode ? ST_WAIT : ST_SAMP;
                end
            end
            ST_WAIT: begin
                if (stop_now) begin
                    next_state = ST_IDLE;
                end else if (trig_pulse) begin
                    next_state = ST_SAMP;
                end
            end
            ST_SAMP, ST_CONV: begin
                if (stop_now) begin
                    next_state = ST_IDLE;
                end else if (wr_cs) begin
                    next_state = ST_SAMP;
                end else if (state == ST_SAMP && step_tick) begin
                    next_state = ST_CONV;
                end else if (conv_last) begin
                    next_state = timer_mode ? ST_WAIT : ST_SAMP;
                end
            end
            default: begin
                next_state = ST_IDLE;
            end
        endcase
    end

    always @(posedge clk_sys) begin
        if (rst) begin
            state     <= ST_IDLE;
            step_cnt  <= 16'h0000;
            conv_cnt  <= {RES_BITS{1'b0}};
            trig_prev <= 1'b0;
        end else begin
            state     <= next_state;
            trig_prev <= trig_sync_sel;
            if (go_samp) begin
                step_cnt <= step_len;
            end else if (step_tick) begin
                step_cnt <= step_len;
            end else if (step_cnt != 16'h0000) begin
                step_cnt <= step_cnt - 16'h0001;
            end
            if (state == ST_SAMP) begin
                conv_cnt <= RES_BITS[RES_BITS-1:0] - {{(RES_BITS-1){1'b0}}, 1'b1};
            end else if ((state == ST_CONV) && step_tick && (conv_cnt != {RES_BITS{1'b0}})) begin
                conv_cnt <= conv_cnt - {{(RES_BITS-1){1'b0}}, 1'b1};
            end
        end
    end

    // final decided code including the last bit
    wire [RES_BITS-1:0] final_code = cmp_high ? sar_trial : (sar_trial & ~sar_mask);

    // registers written by software and results
    always @(posedge clk_sys) begin
        if (rst) begin
            converter_mode_control  <= `SACS_MC_RESET;
            channel_select_register <= `SACS_CS_RESET;
            sw_result_full          <= `SACS_RESULT_FULL_RST;
            timer_result_full       <= `SACS_RESULT_FULL_RST;
            done_irq_flag_bit       <= 1'b0;
            done_irq_mask_bit       <= 1'b0;
        end else begin
            if (wr_mc) begin
                converter_mode_control <= pwdata[7:0];
            end
            if (wr_cs) begin
                channel_select_register <= pwdata[7:0];
            end
            if (wr_mask) begin
                done_irq_mask_bit <= pwdata[`SACS_DONE_BIT];
            end
            if (conv_done) begin
                done_irq_flag_bit <= 1'b1;
            end else if (wr_flag) begin
                done_irq_flag_bit <= pwdata[`SACS_DONE_BIT];
            end
            if (conv_done && timer_mode) begin
                timer_result_full <= {{(16-RES_BITS){1'b0}}, final_code};
            end else if (conv_done) begin
                sw_result_full <= {{(16-RES_BITS){1'b0}}, final_code};
            end
        end
    end

    // apb read data
    always @* begin
        prdata = 32'h0000_0000;
        if (rd_en) begin
            case (paddr)
                `SACS_ADDR_MODE_CTRL: prdata = {24'h000000, converter_mode_control};
                `SACS_ADDR_CHAN_SEL:  prdata = {24'h000000, channel_select_register};
                `SACS_ADDR_SW_FULL:   prdata = {16'h0000, sw_result_full};
                `SACS_ADDR_SW_HIGH:   prdata = {24'h000000, sw_result_full[RES_BITS-1:RES_BITS-8]};
                `SACS_ADDR_SW_LOW:    prdata = {24'h000000, sw_result_full[7:0]};
                `SACS_ADDR_TMR_FULL:  prdata = {16'h0000, timer_result_full};
                `SACS_ADDR_TMR_LOW:   prdata = {24'h000000, timer_result_full[7:0]};
                `SACS_ADDR_IRQ_FLAG:  prdata = {31'h00000000, done_irq_flag_bit};
                `SACS_ADDR_IRQ_MASK:  prdata = {31'h00000000, done_irq_mask_bit};
                `SACS_ADDR_STATUS:    prdata = {30'h00000000, state};
                default:              prdata = 32'h0000_0000;
            endcase
        end
    end

    assign comparator_enable      = converter_mode_control[`SACS_MC_ENABLE_BIT];
    assign sample_hold            = (state == ST_SAMP);
    assign dac_code               = sar_trial;
    assign analog_channel         = channel_select_register[`SACS_CS_CHAN_MSB:0];
    assign conversion_time_select = time_sel;
    assign conversion_done_irq    = done_irq_flag_bit && !done_irq_mask_bit;
endmodule // sacs_sequencer

/* File: include/sacs_regs.vh */
`ifndef SACS_REGS_VH
`define SACS_REGS_VH

// register byte addresses on the apb bus
`define SACS_ADDR_MODE_CTRL   12'h000
`define SACS_ADDR_CHAN_SEL    12'h004
`define SACS_ADDR_SW_FULL     12'h008
`define SACS_ADDR_SW_HIGH     12'h00c
`define SACS_ADDR_SW_LOW      12'h010
`define SACS_ADDR_TMR_FULL    12'h014
`define SACS_ADDR_TMR_LOW     12'h018
`define SACS_ADDR_IRQ_FLAG    12'h01c
`define SACS_ADDR_IRQ_MASK    12'h020
`define SACS_ADDR_STATUS      12'h024

// mode control fields
`define SACS_MC_ENABLE_BIT    0
`define SACS_MC_TIME_LSB      1
`define SACS_MC_TIME_MSB      5
`define SACS_MC_RUN_BIT       7
`define SACS_MC_RESET         8'h00

// channel select fields
`define SACS_CS_CHAN_MSB      3
`define SACS_CS_TRIG_LSB      4
`define SACS_CS_TRIG_MSB      5
`define SACS_CS_RESET         8'h00
`define SACS_TRIG_SOFTWARE    2'h0

// flag and mask bit
`define SACS_DONE_BIT         0

// reset values of results
`define SACS_RESULT_FULL_RST  16'h0000
`define SACS_RESULT_BYTE_RST  8'h00

// result width
`define SACS_RES_BITS         10

// conversion time: base cycles plus per-step cycles times the time field
`define SACS_CONV_BASE        16'h0018
`define SACS_CONV_STEP        16'h0008

`endif

/* File: logic/sacs_sync.v */
`timescale 1ns/1ps
// three-stage synchroniser with agreement of the last two stages
module sacs_sync (
    // clock and reset
    input  wire clk_sys,
    input  wire rst,
    // pin in, clean level out
    input  wire din,
    output reg  dout
);
    reg s1;
    reg s2;
    reg s3;

    always @(posedge clk_sys) begin
        if (rst) begin
            s1   <= 1'b0;
            s2   <= 1'b0;
            s3   <= 1'b0;
            dout <= 1'b0;
        end else begin
            s1 <= din;
            s2 <= s1;
            s3 <= s2;
            if (s2 == s3) begin
                dout <= s3;
            end
        end
    end
endmodule // sacs_sync

/* File: logic/sacs_sar.v */
`timescale 1ns/1ps
`include "sacs_regs.vh"
// successive approximation register, one bit decided per step
module sacs_sar #(
    parameter BITS = `SACS_RES_BITS
) (
    // clock and reset
    input  wire            clk_sys,
    input  wire            rst,
    // control
    input  wire            start,
    input  wire            step,
    input  wire            cmp_high,
    // state
    output reg  [BITS-1:0] trial,
    output reg  [BITS-1:0] mask
);
    always @(posedge clk_sys) begin
        if (rst) begin
            trial <= {BITS{1'b0}};
            mask  <= {BITS{1'b0}};
        end else if (start) begin
            trial <= {1'b1, {(BITS-1){1'b0}}};
            mask  <= {1'b1, {(BITS-1){1'b0}}};
        end else if (step && (mask != {BITS{1'b0}})) begin
            trial <= (cmp_high ? trial : (trial & ~mask)) | (mask >> 1);
            mask  <= mask >> 1;
        end
    end
endmodule // sacs_sar

/* File: tb/sacs_checker.sv */
`timescale 1ns/1ps
`include "sacs_regs.vh"
module sacs_checker (
    // clock and reset
    input wire        clk_sys,
    input wire        rst,
    // apb
    input wire        psel,
    input wire        penable,
    input wire        pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    input wire        pslverr,
    // converter side
    input wire        sample_hold,
    input wire [3:0]  analog_channel,
    input wire [4:0]  conversion_time_select,
    input wire        comparator_enable,
    input wire        conversion_done_irq
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);
    wire wr    = psel && penable && pwrite;
    wire wr_mc = wr && paddr == `SACS_ADDR_MODE_CTRL;
    wire wr_cs = wr && paddr == `SACS_ADDR_CHAN_SEL;
    reg        run_q;
    reg        trig_sw;
    reg        wr_seen;
    reg [15:0] hold_cnt;
    // track run bit, trigger source and sampling length
    always @(posedge clk_sys) begin
        if (rst) begin
            run_q <= 1'b0;
            trig_sw <= 1'b1;
            wr_seen <= 1'b0;
            hold_cnt <= 16'h0000;
        end else begin
            if (wr_mc)
                run_q <= pwdata[7];
            if (wr_cs)
                trig_sw <= pwdata[5:4] == `SACS_TRIG_SOFTWARE;
            wr_seen <= sample_hold ? (wr_seen | wr) : 1'b0;
            hold_cnt <= sample_hold ? hold_cnt + 16'h0001 : 16'h0000;
        end
    end
    time_field_a: assert property (wr_mc |=> conversion_time_select == $past(pwdata[5:1]))
        else $error("time field not taken");
    enable_bit_a: assert property (wr_mc |=> comparator_enable == $past(pwdata[0]))
        else $error("enable bit not taken");
    sw_start_a: assert property (wr_mc && pwdata[7] && !run_q && trig_sw |=> sample_hold)
        else $error("software start missing");
    done_src_a: assert property ($rose(conversion_done_irq) && !$past(wr) |-> !$past(sample_hold))
        else $error("done raised while sampling");
    chan_take_a: assert property (wr_cs |=> analog_channel == $past(pwdata[3:0]))
        else $error("channel not taken");
    chan_restart_a: assert property (wr_cs && run_q && trig_sw |=> sample_hold)
        else $error("no restart on channel write");
    hold_len_a: assert property ($fell(sample_hold) && !wr_seen |->
        hold_cnt == `SACS_CONV_BASE + `SACS_CONV_STEP * {11'h000, conversion_time_select})
        else $error("sampling step length wrong");
    timer_arm_a: assert property (wr_mc && pwdata[7] && !run_q && !trig_sw |=> !sample_hold [*2])
        else $error("timer mode started early");
    stop_now_a: assert property (wr_mc && !pwdata[7] |=> !sample_hold)
        else $error("stop not immediate");
    done_c: cover property ($rose(conversion_done_irq));
    timer_c: cover property ($rose(sample_hold) && !trig_sw);
    slverr_c: cover property (pslverr);
endmodule // sacs_checker

bind sacs_sequencer sacs_checker chk (.clk_sys(clk_sys), .rst(rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pslverr(pslverr), .sample_hold(sample_hold),
    .analog_channel(analog_channel), .conversion_time_select(conversion_time_select),
    .comparator_enable(comparator_enable), .conversion_done_irq(conversion_done_irq));

/* File: tb/sacs_timer_model.sv */
`timescale 1ns/1ps
// timer outputs: one pulse of a few cycles on the chosen line
module sacs_timer_model (
    // clock and reset
    input wire       clk_sys,
    input wire       rst,
    // pulse request
    input wire       fire,
    input wire [1:0] which,
    // trigger lines
    output reg [2:0] trigger_timer
);
    reg [2:0] cnt;
    always @(posedge clk_sys) begin
        if (rst) begin
            trigger_timer <= 3'h0;
            cnt <= 3'h0;
        end else if (fire) begin
            trigger_timer <= 3'h1 << which;
            cnt <= 3'h4;
        end else if (cnt != 3'h0) begin
            cnt <= cnt - 3'h1;
        end else begin
            trigger_timer <= 3'h0;
        end
    end
endmodule // sacs_timer_model

/* File: tb/tb.sv */
`timescale 1ns/1ps
`include "sacs_regs.vh"
module tb;
    reg clk_sys = 0, rst = 1, psel = 0, penable = 0, pwrite = 0, fire = 0;
    reg [11:0] paddr = 12'h000;
    reg [31:0] pwdata = 32'h0, rdata, err;
    reg [1:0] which = 2'h0;
    reg [9:0] target = 10'h000;
    wire [31:0] prdata;
    wire [9:0] dac_code;
    wire [2:0] trigger_timer;
    wire pready, pslverr, conversion_done_irq, comparator_enable, sample_hold;
    wire [3:0] analog_channel;
    wire [4:0] conversion_time_select;
    integer n_mismatch = 0, checks_done = 0, cyc;
    always #20 clk_sys = ~clk_sys;
    // comparator input: high while the analog level is at or above the trial code
    wire cmp_high = target >= dac_code;
    sacs_sequencer dut (.clk_sys(clk_sys), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .trigger_timer(trigger_timer), .cmp_high(cmp_high), .comparator_enable(comparator_enable),
        .sample_hold(sample_hold), .dac_code(dac_code), .analog_channel(analog_channel),
        .conversion_time_select(conversion_time_select), .conversion_done_irq(conversion_done_irq));
    sacs_timer_model tmr (.clk_sys(clk_sys), .rst(rst), .fire(fire), .which(which),
        .trigger_timer(trigger_timer));
    task summarize;
        $display("checks %0d mismatches %0d", checks_done, n_mismatch);
        if (n_mismatch == 0 && checks_done > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    task check(input string nm, input [31:0] e, input [31:0] g);
        checks_done++;
        if (g !== e) begin
            n_mismatch++;
            $display("mismatch %s exp %h got %h", nm, e, g);
        end
    endtask
    task apb(input w, input [11:0] a, input [31:0] d);
        @(posedge clk_sys);
        psel <= 1;
        penable <= 0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_sys);
        penable <= 1;
        cyc = 0;
        do begin
            @(posedge clk_sys);
            cyc++;
        end while (pready !== 1'b1 && cyc < 50);
        rdata = prdata;
        err = {31'h0, pslverr};
        psel <= 0;
        penable <= 0;
        check("pready", 1, {31'h0, pready});
        if (cyc >= 50)
            summarize;
    endtask
    task rchk(input [11:0] a, input [31:0] e, input string nm);
        apb(0, a, 0);
        check(nm, e, rdata);
    endtask
    task wait_irq(input integer lim);
        cyc = 0;
        while (conversion_done_irq !== 1'b1 && cyc < lim) begin
            @(posedge clk_sys);
            cyc++;
        end
        check("irq wait", 1, {31'h0, conversion_done_irq});
        if (cyc >= lim)
            summarize;
    endtask
    initial begin
        repeat (5) @(posedge clk_sys);
        rst <= 0;
        rchk(`SACS_ADDR_SW_FULL, 0, "sw full rst");
        rchk(`SACS_ADDR_SW_LOW, 0, "sw low rst");
        rchk(`SACS_ADDR_TMR_FULL, 0, "tmr full rst");
        rchk(`SACS_ADDR_TMR_LOW, 0, "tmr low rst");
        rchk(12'h0fc, 0, "unmapped");
        check("slverr", 1, err);
        apb(1, `SACS_ADDR_MODE_CTRL, 32'h07);
        rchk(`SACS_ADDR_MODE_CTRL, 32'h07, "mode");
        check("time sel", 3, {27'h0, conversion_time_select});
        check("cmp enable", 1, {31'h0, comparator_enable});
        apb(1, `SACS_ADDR_MODE_CTRL, 32'h01);
        target <= 10'h2a5;
        apb(1, `SACS_ADDR_CHAN_SEL, 32'h02);
        apb(1, `SACS_ADDR_MODE_CTRL, 32'h81);
        wait_irq(2000);
        rchk(`SACS_ADDR_SW_FULL, 32'h2a5, "sw full");
        rchk(`SACS_ADDR_SW_HIGH, 32'ha9, "sw high");
        rchk(`SACS_ADDR_SW_LOW, 32'ha5, "sw low");
        rchk(`SACS_ADDR_TMR_FULL, 0, "tmr untouched");
        apb(1, `SACS_ADDR_IRQ_FLAG, 0);
        repeat (100) @(posedge clk_sys);
        apb(1, `SACS_ADDR_IRQ_MASK, 1);
        target <= 10'h11b;
        apb(1, `SACS_ADDR_CHAN_SEL, 32'h05);
        apb(1, `SACS_ADDR_IRQ_FLAG, 0);
        apb(1, `SACS_ADDR_IRQ_MASK, 0);
        wait_irq(600);
        // sampling step plus ten bit steps at time field 0; the wait began six edges after the write
        check("chan to done", 11 * `SACS_CONV_BASE, cyc + 5);
        check("channel", 5, {28'h0, analog_channel});
        rchk(`SACS_ADDR_SW_FULL, 32'h11b, "new chan");
        apb(1, `SACS_ADDR_IRQ_FLAG, 0);
        wait_irq(600);
        target <= 10'h3ff;
        apb(1, `SACS_ADDR_IRQ_FLAG, 0);
        repeat (50) @(posedge clk_sys);
        apb(1, `SACS_ADDR_MODE_CTRL, 32'h01);
        rchk(`SACS_ADDR_STATUS, 0, "stopped");
        repeat (400) @(posedge clk_sys);
        rchk(`SACS_ADDR_SW_FULL, 32'h11b, "kept");
        check("no irq", 0, {31'h0, conversion_done_irq});
        target <= 10'h13c;
        apb(1, `SACS_ADDR_CHAN_SEL, 32'h23);
        apb(1, `SACS_ADDR_MODE_CTRL, 32'h81);
        repeat (20) @(posedge clk_sys);
        rchk(`SACS_ADDR_STATUS, 1, "armed");
        which <= 2'h1;
        fire <= 1;
        @(posedge clk_sys);
        fire <= 0;
        wait_irq(600);
        rchk(`SACS_ADDR_TMR_FULL, 32'h13c, "tmr full");
        rchk(`SACS_ADDR_TMR_LOW, 32'h3c, "tmr low");
        rchk(`SACS_ADDR_SW_FULL, 32'h11b, "sw kept");
        rchk(`SACS_ADDR_STATUS, 1, "rearmed");
        check("dac code", 32'h13c, {22'h0, dac_code});
        rchk(`SACS_ADDR_IRQ_FLAG, 1, "flag set");
        apb(1, `SACS_ADDR_MODE_CTRL, 32'h01);
        apb(1, `SACS_ADDR_MODE_CTRL, 32'h00);
        apb(1, `SACS_ADDR_IRQ_FLAG, 0);
        check("cmp disable", 0, {31'h0, comparator_enable});
        rchk(`SACS_ADDR_IRQ_FLAG, 0, "flag clear");
        rchk(`SACS_ADDR_STATUS, 0, "finished");
        summarize;
    end
endmodule // tb
